// *** hw/global_regs_params.svh ***
// Register indices, field positions, reset values and limits of the bank.
// Operation
// - Valid in-band frame sets good-frame bit 31
// - Response sent sets bit 30
// - All frame commands done sets bit 29
// - Matching-tag frame clears done and error flags
// - Destination mismatch sets bit 14 when checking
// - Wrong access format sets bit 13
// - Access code not 1 or 2 sets bit 12
// - Unknown command code sets bit 11
// - Frame over 320 bytes: bit 10, no response
// - Bits 6:0 give unknown command position
// - Select bit chooses LED or general output
// - Bit zero is first pin, alternating pins
// - General output follows output-control bit level
// - Power mode field decodes four settings
// - PLL power-down bit disables the PLL
// - Latched strap values readable in bits 9:0
// - Control bit 30 enables destination check, discard
`ifndef GLOBAL_REGS_PARAMS_SVH
`define GLOBAL_REGS_PARAMS_SVH
// Register indices; the byte address is four times the index.
`define IDX_PAD_DRIVE 10'h10d
`define IDX_INBAND_CTRL 10'h104
`define IDX_INBAND_STATUS 10'h110
`define IDX_PIN_SELECT 10'h120
`define IDX_PIN_OUTPUT 10'h124
`define IDX_POWER_DOWN 10'h201
`define IDX_STRAP 10'h210
`define IDX_ADDR_LOW 10'h300
`define IDX_ADDR_HIGH 10'h301
`define IDX_IRQ_STATUS 10'h140
`define IDX_IRQ_MASK 10'h141
// Status bit positions.
`define BIT_GOOD 31
`define BIT_RESP 30
`define BIT_EXEC 29
`define BIT_ADDR_ERR 14
`define BIT_FMT_ERR 13
`define BIT_CODE_ERR 12
`define BIT_CMD_ERR 11
`define BIT_SIZE_ERR 10
// Control bit positions.
`define BIT_DEST_CHECK 30
`define BIT_PLL_DOWN 5
// Reset values.
`define RST_PAD_DRIVE 8'h62
`define RST_TAG 16'h40fe
`define RST_ADDR_LOW 32'ha1ffffff
`define RST_ADDR_HIGH 16'h0010
// Frame limits and constants.
`define ACCESS_FORMAT 16'h9800
`define ACCESS_CODE_A 16'h0001
`define ACCESS_CODE_B 16'h0002
`define MAX_FRAME_BYTES 10'h140
`define NUM_PINS 10
`endif

// *** hw/global_regs_pkg.sv ***
// Types shared by the global register bank.
package global_regs_pkg;
	// Power management mode field encodings.
	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_ENERGY_DETECT = 2'b01,
		PM_SOFT_DOWN = 2'b10,
		PM_INVALID = 2'b11
	} power_mode_t;
	// Summary of one parsed in-band frame, given by the frame parser.
	typedef struct packed {
		logic [15:0] tag;
		logic [47:0] destAddr;
		logic [15:0] accessFormat;
		logic [15:0] accessCode;
		logic cmdUnknown;
		logic [6:0] cmdLocation;
		logic [9:0] length;
	} inband_frame_t;
endpackage

// *** hw/global_inband_led_power_regs.sv ***
// Global in-band status, indicator pin and power control register bank.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "global_regs_params.svh"
module global_inband_led_power_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic frameDone,
	input wire global_regs_pkg::inband_frame_t frameInfo,
	input wire logic responseSent,
	input wire logic executionDone,
	input wire logic [9:0] ledDrive,
	input wire logic [9:0] strapPins,
	output logic [9:0] indicatorPin,
	output logic discardFrame,
	output logic suppressResponse,
	output logic pllPowerDown,
	output logic energyDetectPowerdown,
	output logic softPowerDown,
	output logic [7:0] padDriveStrength,
	output logic irq
);
	// Software-visible state.
	logic [31:0] inbandStatus;
	logic [31:0] inbandCtrl;
	logic [9:0] pinSelect;
	logic [9:0] pinOutput;
	logic [2:0] powerCtrl;
	logic [9:0] strapValue;
	logic strapTaken;
	logic [31:0] addrLow;
	logic [15:0] addrHigh;
	logic [3:0] irqStatus;
	logic [3:0] irqMask;
	// Strap synchroniser stages; the first is read only by the second.
	logic [9:0] strapMeta;
	logic [9:0] strapSync;
	// Data-phase state of the bus.
	logic wrPending;
	logic [9:0] wrIndex;

	// Address phase decode.
	wire addrPhase = hsel && htrans[1] && hready;
	wire [9:0] aIndex = haddr[11:2];
	wire rdStart = addrPhase && !hwrite;
	wire irqRead = rdStart && aIndex == `IDX_IRQ_STATUS;
	wire wrPad = wrPending && wrIndex == `IDX_PAD_DRIVE;
	wire wrCtrl = wrPending && wrIndex == `IDX_INBAND_CTRL;
	wire wrSel = wrPending && wrIndex == `IDX_PIN_SELECT;
	wire wrOut = wrPending && wrIndex == `IDX_PIN_OUTPUT;
	wire wrPwr = wrPending && wrIndex == `IDX_POWER_DOWN;
	wire wrAddrLow = wrPending && wrIndex == `IDX_ADDR_LOW;
	wire wrAddrHigh = wrPending && wrIndex == `IDX_ADDR_HIGH;
	wire wrMask = wrPending && wrIndex == `IDX_IRQ_MASK;

	// Read multiplexer; unmapped indices read zero.
	logic [31:0] readValue;
	always_comb begin
		case (aIndex)
			`IDX_PAD_DRIVE: readValue = {24'h000000, padDriveStrength};
			`IDX_INBAND_CTRL: readValue = inbandCtrl;
			`IDX_INBAND_STATUS: readValue = inbandStatus;
			`IDX_PIN_SELECT: readValue = {22'h000000, pinSelect};
			`IDX_PIN_OUTPUT: readValue = {22'h000000, pinOutput};
			`IDX_POWER_DOWN: readValue = {26'h0000000, powerCtrl, 3'h0};
			`IDX_STRAP: readValue = {22'h000000, strapValue};
			`IDX_ADDR_LOW: readValue = addrLow;
			`IDX_ADDR_HIGH: readValue = {16'h0000, addrHigh};
			`IDX_IRQ_STATUS: readValue = {28'h0000000, irqStatus};
			`IDX_IRQ_MASK: readValue = {28'h0000000, irqMask};
			default: readValue = 32'h00000000;
		endcase
	end

	// Frame checks, evaluated when the parser reports a finished frame.
	wire [47:0] switchAddr = {addrHigh, addrLow};
	wire destCheck = inbandCtrl[`BIT_DEST_CHECK];
	wire tagHit = frameDone && frameInfo.tag == inbandCtrl[15:0];
	wire addrErr = destCheck && frameInfo.destAddr != switchAddr;
	wire fmtErr = frameInfo.accessFormat != `ACCESS_FORMAT;
	wire codeErr = frameInfo.accessCode != `ACCESS_CODE_A &&
		frameInfo.accessCode != `ACCESS_CODE_B;
	wire cmdErr = frameInfo.cmdUnknown;
	wire sizeErr = frameInfo.length > `MAX_FRAME_BYTES;
	wire anyErr = addrErr || fmtErr || codeErr || cmdErr || sizeErr;
	wire goodFrame = frameDone && !anyErr;

	// Next status: a matching tag clears, then this frame's events set.
	logic [31:0] next_status;
	always_comb begin
		next_status = inbandStatus;
		if (tagHit) begin
			// Only the done and error fields clear; good-frame holds.
			next_status[`BIT_RESP:`BIT_EXEC] = 2'b00;
			next_status[`BIT_ADDR_ERR:0] = 15'h0000;
		end
		if (goodFrame) begin
			next_status[`BIT_GOOD] = 1'b1;
		end
		if (responseSent) begin
			next_status[`BIT_RESP] = 1'b1;
		end
		if (executionDone) begin
			next_status[`BIT_EXEC] = 1'b1;
		end
		if (frameDone) begin
			next_status[`BIT_ADDR_ERR] = next_status[`BIT_ADDR_ERR] | addrErr;
			next_status[`BIT_FMT_ERR] = next_status[`BIT_FMT_ERR] | fmtErr;
			next_status[`BIT_CODE_ERR] = next_status[`BIT_CODE_ERR] | codeErr;
			next_status[`BIT_SIZE_ERR] = next_status[`BIT_SIZE_ERR] | sizeErr;
			if (cmdErr) begin
				next_status[`BIT_CMD_ERR] = 1'b1;
				next_status[6:0] = frameInfo.cmdLocation;
			end
		end
	end

	// Interrupt events: good frame, response, execution, any error.
	wire [3:0] irqEvent = {frameDone && anyErr, executionDone,
		responseSent, goodFrame};
	// Read clears the sticky bits, but a new event in the same cycle wins.
	wire [3:0] next_irqStatus = (irqRead ? 4'h0 : irqStatus) | irqEvent;

	// Power mode decode.
	global_regs_pkg::power_mode_t powerMode;
	assign powerMode = global_regs_pkg::power_mode_t'(powerCtrl[1:0]);

	// Per-pin choice between LED drive and the general output bit.
	logic [9:0] next_pin;
	genvar p;
	generate
		for (p = 0; p < `NUM_PINS; p++) begin : g_pin
			// Bit p maps to pin p in first-to-last, alternating order.
			assign next_pin[p] = pinSelect[p] ? pinOutput[p] : ledDrive[p];
		end
	endgenerate

	// Bus interface: accept every phase at once, always OKAY.
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPending <= 1'b0;
			wrIndex <= 10'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPending <= addrPhase && hwrite;
			wrIndex <= aIndex;
			hrdata <= rdStart ? readValue : 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Software-written registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			padDriveStrength <= `RST_PAD_DRIVE;
			inbandCtrl <= {16'h0000, `RST_TAG};
			pinSelect <= 10'h000;
			pinOutput <= 10'h000;
			powerCtrl <= 3'h0;
			addrLow <= `RST_ADDR_LOW;
			addrHigh <= `RST_ADDR_HIGH;
			irqMask <= 4'h0;
		end else begin
			if (wrPad) begin
				padDriveStrength <= hwdata[7:0];
			end
			if (wrCtrl) begin
				// Only the destination-check bit and the tag are held.
				inbandCtrl <= {1'b0, hwdata[30], 14'h0000, hwdata[15:0]};
			end
			if (wrSel) begin
				pinSelect <= hwdata[9:0];
			end
			if (wrOut) begin
				pinOutput <= hwdata[9:0];
			end
			if (wrPwr) begin
				powerCtrl <= hwdata[5:3];
			end
			if (wrAddrLow) begin
				addrLow <= hwdata;
			end
			if (wrAddrHigh) begin
				addrHigh <= hwdata[15:0];
			end
			if (wrMask) begin
				irqMask <= hwdata[3:0];
			end
		end
	end

	// Hardware-set status, interrupt and frame-handling outputs.
	always_ff @(posedge clk) begin
		if (rst) begin
			inbandStatus <= 32'h00000000;
			irqStatus <= 4'h0;
			irq <= 1'b0;
			discardFrame <= 1'b0;
			suppressResponse <= 1'b0;
		end else begin
			inbandStatus <= next_status;
			irqStatus <= next_irqStatus;
			irq <= |(next_irqStatus & irqMask);
			discardFrame <= frameDone && addrErr;
			suppressResponse <= frameDone && sizeErr;
		end
	end

	// Pin and power outputs, registered.
	always_ff @(posedge clk) begin
		if (rst) begin
			indicatorPin <= 10'h000;
			pllPowerDown <= 1'b0;
			energyDetectPowerdown <= 1'b0;
			softPowerDown <= 1'b0;
		end else begin
			indicatorPin <= next_pin;
			pllPowerDown <= powerCtrl[2];
			energyDetectPowerdown <= powerMode == global_regs_pkg::PM_ENERGY_DETECT;
			softPowerDown <= powerMode == global_regs_pkg::PM_SOFT_DOWN;
		end
	end

	// Strap synchroniser, free running so it is settled at release.
	always_ff @(posedge clk) begin
		strapMeta <= strapPins;
		strapSync <= strapMeta;
	end

	// Straps are caught once, on the first edge after reset release.
	always_ff @(posedge clk) begin
		if (rst) begin
			strapTaken <= 1'b0;
			strapValue <= 10'h000;
		end else if (!strapTaken) begin
			strapTaken <= 1'b1;
			strapValue <= strapSync;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	good_flag_set_a: assert property (goodFrame |=> inbandStatus[31])
		else $error("good frame did not set bit 31");
	resp_flag_set_a: assert property (responseSent |=> inbandStatus[30])
		else $error("response sent did not set bit 30");
	exec_flag_set_a: assert property (executionDone |=> inbandStatus[29])
		else $error("execution done did not set bit 29");
	tag_clear_a: assert property (tagHit && !anyErr && !responseSent &&
		!executionDone |=> inbandStatus[30:0] == 31'h0)
		else $error("matching tag did not clear flags");
	addr_err_a: assert property (frameDone && !destCheck && !tagHit
		|=> inbandStatus[14] == $past(inbandStatus[14]))
		else $error("address error set with checking off");
	code_err_a: assert property (frameDone &&
		frameInfo.accessCode == 16'h0003 |=> inbandStatus[12])
		else $error("bad access code not flagged");
	size_err_a: assert property (frameDone && frameInfo.length == 10'h141
		|=> inbandStatus[10] && suppressResponse)
		else $error("oversize frame not flagged");
	cmd_loc_a: assert property (frameDone && cmdErr
		|=> inbandStatus[6:0] == $past(frameInfo.cmdLocation))
		else $error("command error location wrong");
	gpo_pin_a: assert property (wrSel && hwdata[0] ##1 wrOut && !hwdata[0]
		##1 !wrSel[*2] |-> indicatorPin[0] == 1'b0)
		else $error("general output pin not low");
	pll_down_a: assert property (wrPwr && hwdata[5] |=> ##1 pllPowerDown)
		else $error("PLL power-down not applied");
	status_hold_a: assert property (!frameDone && !responseSent &&
		!executionDone |=> $stable(inbandStatus))
		else $error("status changed without an event");

	frame_error_c: cover property (frameDone && anyErr ##1 irqStatus[3]);
	good_frame_c: cover property (goodFrame ##[1:20] responseSent);
	irq_read_c: cover property (irq ##[1:10] irqRead);
endmodule // global_inband_led_power_regs
`default_nettype wire

// *** test/frame_host_model.sv ***
// Behavioural remote management host that delivers parsed in-band frames.
`timescale 1ns/100ps
`default_nettype none
module frame_host_model (
	input wire logic clk,
	output logic frameDone,
	output global_regs_pkg::inband_frame_t frameInfo,
	output logic responseSent,
	output logic executionDone
);
	// Quiet outputs; the summary is scrambled while no frame ends.
	initial begin
		frameDone = 1'b0;
		frameInfo = '1;
		responseSent = 1'b0;
		executionDone = 1'b0;
	end
	// Hands one frame summary over for exactly one cycle.
	task automatic send(input global_regs_pkg::inband_frame_t f);
		@(posedge clk);
		frameDone <= 1'b1;
		frameInfo <= f;
		@(posedge clk);
		frameDone <= 1'b0;
		frameInfo <= ~f;
	endtask
	// Pulses response-sent (sel 0) or execution-done (sel 1) once.
	task automatic pulse(input logic sel);
		@(posedge clk);
		if (sel) begin
			executionDone <= 1'b1;
		end else begin
			responseSent <= 1'b1;
		end
		@(posedge clk);
		responseSent <= 1'b0;
		executionDone <= 1'b0;
	endtask
endmodule // frame_host_model
`default_nettype wire

// *** test/global_inband_led_power_regs_test.sv ***
// Self-checking bench for the global in-band, pin and power register bank.
`timescale 1ns/100ps
`default_nettype none
`include "global_regs_params.svh"
module global_inband_led_power_regs_test;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [9:0] ledDrive = '0, strapPins = 10'h2a5, indicatorPin;
	logic hready, hreadyout, hresp, frameDone, responseSent, executionDone;
	logic discardFrame, suppressResponse, irq;
	logic pllPowerDown, energyDetectPowerdown, softPowerDown;
	logic [7:0] padDriveStrength;
	global_regs_pkg::inband_frame_t frameInfo;
	int badCount = 0, numChecks = 0, cycles = 0;
	// Default switch address and status bits used by the expectations.
	localparam logic [47:0] SW_ADDR = {`RST_ADDR_HIGH, `RST_ADDR_LOW};
	localparam logic [31:0] GOOD = 32'h1 << `BIT_GOOD;
	localparam logic [31:0] RESP = 32'h1 << `BIT_RESP;
	localparam logic [31:0] EXEC = 32'h1 << `BIT_EXEC;
	// The only slave drives the bus ready.
	assign hready = hreadyout;
	// Clock of 50 ns period.
	always #25 clk = ~clk;
	global_inband_led_power_regs u_global_inband_led_power_regs (.clk(clk),
		.rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.frameDone(frameDone), .frameInfo(frameInfo),
		.responseSent(responseSent), .executionDone(executionDone),
		.ledDrive(ledDrive), .strapPins(strapPins),
		.indicatorPin(indicatorPin), .discardFrame(discardFrame),
		.suppressResponse(suppressResponse), .pllPowerDown(pllPowerDown),
		.energyDetectPowerdown(energyDetectPowerdown),
		.softPowerDown(softPowerDown), .padDriveStrength(padDriveStrength),
		.irq(irq));
	frame_host_model u_frame_host_model (.clk(clk), .frameDone(frameDone),
		.frameInfo(frameInfo), .responseSent(responseSent),
		.executionDone(executionDone));
	// Prints the counts and the verdict, then stops.
	task automatic testDone;
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			badCount++;
			testDone;
		end
	end
	// Compares one value and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One single AHB transfer to a register index.
	task automatic acc(input logic [9:0] idx, input logic [31:0] d,
		input logic w, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] r;
		acc(idx, d, 1'b1, r);
	endtask
	task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		acc(idx, 32'h0, 1'b0, r);
		chk(r, exp);
	endtask
	// Lets a register write reach the registered outputs.
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	function automatic global_regs_pkg::inband_frame_t mk(
		input logic [15:0] tag, input logic [47:0] dst,
		input logic [15:0] fmt, input logic [15:0] code,
		input logic unk, input logic [6:0] loc, input logic [9:0] len);
		mk = {tag, dst, fmt, code, unk, loc, len};
	endfunction
	// Reset values, read-only status, straps and an unmapped place.
	task automatic resetValues;
		rdChk(`IDX_PAD_DRIVE, {24'h0, `RST_PAD_DRIVE});
		chk({24'h0, padDriveStrength}, {24'h0, `RST_PAD_DRIVE});
		wr(`IDX_INBAND_STATUS, 32'hffffffff);
		rdChk(`IDX_INBAND_STATUS, 32'h0);
		rdChk(`IDX_PIN_SELECT, 32'h0);
		rdChk(`IDX_PIN_OUTPUT, 32'h0);
		rdChk(`IDX_POWER_DOWN, 32'h0);
		rdChk(`IDX_STRAP, 32'h2a5);
		rdChk(10'h3ff, 32'h0);
	endtask
	// Good frame, response and execution flags with the interrupt path.
	task automatic goodFrame;
		wr(`IDX_IRQ_MASK, 32'hf);
		u_frame_host_model.send(mk(`RST_TAG, SW_ADDR, `ACCESS_FORMAT,
			`ACCESS_CODE_A, 1'b0, 7'h0, 10'd64));
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		rdChk(`IDX_INBAND_STATUS, GOOD);
		rdChk(`IDX_IRQ_STATUS, 32'h1);
		settle;
		chk({31'h0, irq}, 32'h0);
		wr(`IDX_IRQ_MASK, 32'h0);
		u_frame_host_model.pulse(1'b0);
		u_frame_host_model.pulse(1'b1);
		settle;
		chk({31'h0, irq}, 32'h0);
		rdChk(`IDX_INBAND_STATUS, GOOD | RESP | EXEC);
		wr(`IDX_IRQ_MASK, 32'hf);
		settle;
		chk({31'h0, irq}, 32'h1);
		rdChk(`IDX_IRQ_STATUS, 32'h6);
	endtask
	// Every error but the address error at once, then destination checking and tag clearing.
	task automatic errFrames;
		u_frame_host_model.send(mk(16'h1234, SW_ADDR, 16'h9801, 16'h0003,
			1'b1, 7'h55, 10'd321));
		#1;
		chk({31'h0, suppressResponse}, 32'h1);
		rdChk(`IDX_INBAND_STATUS, GOOD | RESP | EXEC | 32'h3c55);
		wr(`IDX_INBAND_CTRL, (32'h1 << `BIT_DEST_CHECK) | `RST_TAG);
		u_frame_host_model.send(mk(`RST_TAG, SW_ADDR ^ 48'h1, `ACCESS_FORMAT,
			`ACCESS_CODE_B, 1'b0, 7'h0, 10'd320));
		#1;
		chk({30'h0, discardFrame, suppressResponse}, 32'h2);
		rdChk(`IDX_INBAND_STATUS, GOOD | 32'h4000);
		rdChk(`IDX_INBAND_STATUS, GOOD | 32'h4000);
		wr(`IDX_INBAND_CTRL, {16'h0, `RST_TAG});
		u_frame_host_model.send(mk(`RST_TAG, SW_ADDR ^ 48'h1, `ACCESS_FORMAT,
			`ACCESS_CODE_A, 1'b0, 7'h0, 10'd64));
		#1;
		chk({31'h0, discardFrame}, 32'h0);
		rdChk(`IDX_INBAND_STATUS, GOOD);
	endtask
	// Indicator pins as general outputs and as LEDs.
	task automatic pins;
		wr(`IDX_PIN_SELECT, 32'h3ff);
		wr(`IDX_PIN_OUTPUT, 32'h155);
		settle;
		chk({22'h0, indicatorPin}, 32'h155);
		ledDrive <= 10'h0f0;
		wr(`IDX_PIN_SELECT, 32'h001);
		wr(`IDX_PIN_OUTPUT, 32'h001);
		settle;
		chk({22'h0, indicatorPin}, 32'h0f1);
		rdChk(`IDX_PIN_SELECT, 32'h001);
	endtask
	// All power mode codes with and without the PLL power-down bit.
	task automatic power;
		for (int i = 0; i < 8; i++) begin
			wr(`IDX_POWER_DOWN, 32'(i) << 3);
			settle;
			chk({29'h0, pllPowerDown, softPowerDown, energyDetectPowerdown},
				{29'h0, i[2], i[1:0] == 2'b10, i[1:0] == 2'b01});
			rdChk(`IDX_POWER_DOWN, 32'(i) << 3);
		end
	endtask
	// Main sequence after a reset of three cycles.
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		resetValues;
		goodFrame;
		errFrames;
		pins;
		power;
		testDone;
	end
endmodule // global_inband_led_power_regs_test
`default_nettype wire
